// [pcfu_feed_unit.sv]
`include "pcfu_params.svh"

// Summary of operation
// - control writes stay pending until a valid unlock sequence completes.
// - active enable turns the loop on, locking to active multiplier and divider.
// - loop clock drives the chip only when active connect and enable are both set.
// - every clock source change is break-before-make, so no glitch reaches the chip.
// - lock is never checked before connecting, loss of lock never disconnects.
// - configuration bits 4:0 hold the multiplier select sent to the loop.
// - configuration bits 6:5 hold the divider select sent to the loop.
// - configuration writes stay pending until a valid unlock sequence completes.
// - status bits 4:0 and 6:5 return the active multiplier and divider.
// - status bit 8 shows active enable, cleared on power down.
// - status bit 9 shows active connect, cleared on power down.
// - status bit 10 is one while the loop reports lock.
// - the lock flag is driven to the interrupt controller.
// - connect without enable behaves as both cleared: loop off, oscillator clock.
// - unlock is 0xAA then 0x55 written to the unlock register.
// - the two unlock writes must be consecutive bus cycles.
// - wrong value, order or spacing leaves active values unchanged.
// - wakeup does not restore enable and connect; loop stays off.
// - after reset the loop is off and the oscillator drives the chip.
module pcfu_feed_unit #(
    parameter int BREAK_CYC = `PCFU_BREAK_CYC
) (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic nrst_in,
    // peripheral bus, one cycle per strobe
    input wire logic bus_sel_in,
    input wire logic bus_wr_in,
    input wire logic [31:0] bus_addr_in,
    input wire logic [7:0] bus_wdata_in,
    output pcfu_pkg::pcfu_rdata_t bus_rdata_out,
    // loop interface
    input wire logic lock_in,
    input wire logic power_down_in,
    output logic pll_enable_out,
    output logic [4:0] pll_mult_out,
    output logic [1:0] pll_div_out,
    // clock source gates
    output logic osc_clk_gate_out,
    output logic pll_clk_gate_out,
    // interrupt controller source
    output logic lock_irq_out
);
    import pcfu_pkg::*;

    pcfu_link_if link ();

    logic [1:0] ctrl_pend_q;
    logic [6:0] cfg_pend_q;
    logic act_en_q;
    logic act_con_q;
    logic [4:0] act_mul_q;
    logic [1:0] act_div_q;
    logic lock_meta_q;
    logic lock_sync_q;
    logic lock_irq_q;
    pcfu_rdata_t rdata_q;
    pcfu_rdata_t rdata_d;
    logic osc_gate_q;
    logic pll_gate_q;

    // address decoding
    wire hit_ctrl = (bus_addr_in == `PCFU_ADDR_CTRL);
    wire hit_cfg = (bus_addr_in == `PCFU_ADDR_CFG);
    wire hit_stat = (bus_addr_in == `PCFU_ADDR_STAT);
    wire hit_feed = (bus_addr_in == `PCFU_ADDR_FEED);
    wire bus_write = bus_sel_in & bus_wr_in;
    wire bus_read = bus_sel_in & ~bus_wr_in;
    wire wr_ctrl = bus_write & hit_ctrl;
    wire wr_cfg = bus_write & hit_cfg;
    wire commit = link.commit;

    // bus view handed to the unlock detector
    assign link.bus_cyc = bus_sel_in;
    assign link.bus_wr = bus_wr_in;
    assign link.feed_hit = hit_feed;
    assign link.wdata = bus_wdata_in;

    pcfu_unlock_det u_unlock (
        .sys_clk_in(sys_clk_in),
        .nrst_in(nrst_in),
        .link(link.unlock_dev)
    );

    // pending holding registers, reserved bits dropped on write
    // configuration is held the same way
    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            ctrl_pend_q <= `PCFU_CTRL_RESET;
            cfg_pend_q <= `PCFU_CFG_RESET;
        end else begin
            if (wr_ctrl) begin
                ctrl_pend_q <= bus_wdata_in[1:0];
            end
            if (wr_cfg) begin
                cfg_pend_q <= bus_wdata_in[6:0];
            end
        end
    end

    // pending fields split out for the commit
    wire pend_en = ctrl_pend_q[`PCFU_CTRL_EN_BIT];
    wire pend_con = ctrl_pend_q[`PCFU_CTRL_CON_BIT];
    wire [4:0] pend_mul = cfg_pend_q[`PCFU_CFG_MUL_MSB:`PCFU_CFG_MUL_LSB];
    wire [1:0] pend_div = cfg_pend_q[`PCFU_CFG_DIV_MSB:`PCFU_CFG_DIV_LSB];

    // power down forces enable low over any commit
    // nothing brings the old values back after wakeup
    wire act_en_d = power_down_in ? 1'b0 : (commit ? pend_en : act_en_q);
    // power down forces connect low over any commit
    wire act_con_d = power_down_in ? 1'b0 : (commit ? pend_con : act_con_q);
    // active fields move only on a commit pulse
    wire [4:0] act_mul_d = commit ? pend_mul : act_mul_q;
    wire [1:0] act_div_d = commit ? pend_div : act_div_q;

    // active copies start with the loop off and bypassed
    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            act_en_q <= 1'b0;
            act_con_q <= 1'b0;
            act_mul_q <= 5'h00;
            act_div_q <= 2'h0;
        end else begin
            act_en_q <= act_en_d;
            act_con_q <= act_con_d;
            act_mul_q <= act_mul_d;
            act_div_q <= act_div_d;
        end
    end

    // loop drive outputs, registered copies of the active values
    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            pll_enable_out <= 1'b0;
            pll_mult_out <= 5'h00;
            pll_div_out <= 2'h0;
        end else begin
            pll_enable_out <= act_en_d;
            pll_mult_out <= act_mul_d;
            pll_div_out <= act_div_d;
        end
    end

    // lock comes from the analog loop, so it is synchronised before use
    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            lock_meta_q <= 1'b0;
            lock_sync_q <= 1'b0;
        end else begin
            lock_meta_q <= lock_in;
            lock_sync_q <= lock_meta_q;
        end
    end

    // level source for the interrupt controller, masking is done there
    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            lock_irq_q <= 1'b0;
        end else begin
            lock_irq_q <= lock_sync_q;
        end
    end
    assign lock_irq_out = lock_irq_q;

    // loop clock requested only with both active bits set
    // lock plays no part in the request, so loss of lock never disconnects
    assign link.want_pll = act_en_q & act_con_q;

    pcfu_clk_switch #(
        .BREAK_CYC(BREAK_CYC)
    ) u_switch (
        .sys_clk_in(sys_clk_in),
        .nrst_in(nrst_in),
        .link(link.switch_dev)
    );

    // gate flops live in the switch; named copies here for reading
    assign osc_gate_q = link.osc_gate;
    assign pll_gate_q = link.pll_gate;
    assign osc_clk_gate_out = osc_gate_q;
    assign pll_clk_gate_out = pll_gate_q;

    // status word assembly
    // active values, not pending ones
    wire [15:0] stat_word = {5'h00, lock_sync_q, act_con_q, act_en_q, 1'b0, act_div_q, act_mul_q};

    // read mux; unmapped addresses and the write-only register return zero
    always_comb begin
        rdata_d = 16'h0000;
        if (hit_ctrl) begin
            rdata_d = {14'h0000, ctrl_pend_q};
        end else if (hit_cfg) begin
            rdata_d = {9'h000, cfg_pend_q};
        end else if (hit_stat) begin
            rdata_d = stat_word;
        end else begin
            rdata_d = 16'h0000;
        end
    end

    // read data registered and held until the next read
    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            rdata_q <= 16'h0000;
        end else if (bus_read) begin
            rdata_q <= rdata_d;
        end
    end
    assign bus_rdata_out = rdata_q;

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!nrst_in);

    a_commit_enable: assert property (commit && !power_down_in |=> act_en_q == $past(pend_en) && act_con_q == $past(pend_con))
        else $error("control not taken on commit");
    a_commit_config: assert property (commit |=> act_mul_q == $past(pend_mul) && act_div_q == $past(pend_div))
        else $error("configuration not taken on commit");
    a_hold_no_commit: assert property (!commit && !power_down_in |=> $stable(act_en_q) && $stable(act_con_q) && $stable(act_mul_q) && $stable(act_div_q))
        else $error("active values moved without commit");
    a_pd_clears: assert property (power_down_in |=> !act_en_q && !act_con_q ##1 !pll_enable_out)
        else $error("power down did not clear enable and connect");
    a_enable_drive: assert property (commit && pend_en && !power_down_in |=> ##1 pll_enable_out)
        else $error("loop not enabled after commit");
    a_stat_fields: assert property (bus_read && hit_stat |=> bus_rdata_out[6:0] == $past({act_div_q, act_mul_q}) && bus_rdata_out[9:8] == $past({act_con_q, act_en_q}))
        else $error("status fields do not match active values");
    a_stat_lock: assert property (bus_read && hit_stat |=> bus_rdata_out[`PCFU_STAT_LOCK_BIT] == $past(lock_sync_q))
        else $error("status lock bit wrong");
    a_feed_reads_zero: assert property (bus_read && (hit_feed || !(hit_ctrl || hit_cfg || hit_stat)) |=> bus_rdata_out == 16'h0000)
        else $error("write-only or unmapped read not zero");
    a_lock_irq: assert property ($rose(lock_sync_q) |=> lock_irq_out)
        else $error("lock did not reach interrupt source");
    a_connect_alone: assert property (!act_en_q [*8] |-> !pll_gate_q)
        else $error("loop clock selected without enable");
    a_switch_to_pll: assert property ($rose(act_en_q && act_con_q) |-> ##[1:8] pll_gate_q)
        else $error("loop clock not selected after enable and connect");
    a_lock_loss_kept: assert property (pll_gate_q && act_en_q && act_con_q && $fell(lock_sync_q) |=> pll_gate_q)
        else $error("lock loss disconnected the loop");

    c_commit: cover property (wr_ctrl ##[1:8] commit);
    c_lock_irq: cover property ($rose(lock_irq_out));
    c_pd_while_pll: cover property (pll_gate_q && power_down_in);
endmodule

// [pcfu_params.svh]
`ifndef PCFU_PARAMS_SVH
`define PCFU_PARAMS_SVH

// register byte addresses on the peripheral bus
`define PCFU_ADDR_CTRL 32'hE01FC080
`define PCFU_ADDR_CFG 32'hE01FC084
`define PCFU_ADDR_STAT 32'hE01FC088
`define PCFU_ADDR_FEED 32'hE01FC08C

// control register fields
`define PCFU_CTRL_EN_BIT 0
`define PCFU_CTRL_CON_BIT 1
`define PCFU_CTRL_RESET 2'h0

// configuration register fields
`define PCFU_CFG_MUL_LSB 0
`define PCFU_CFG_MUL_MSB 4
`define PCFU_CFG_DIV_LSB 5
`define PCFU_CFG_DIV_MSB 6
`define PCFU_CFG_RESET 7'h00

// status register fields
`define PCFU_STAT_EN_BIT 8
`define PCFU_STAT_CON_BIT 9
`define PCFU_STAT_LOCK_BIT 10

// unlock keys, in the order they must arrive
`define PCFU_KEY_FIRST 8'hAA
`define PCFU_KEY_SECOND 8'h55

// timing: break-before-make gap on a clock source change
`define PCFU_CLK_PERIOD_NS 5
`define PCFU_BREAK_NS 20
`define PCFU_BREAK_CYC ((`PCFU_BREAK_NS + `PCFU_CLK_PERIOD_NS - 1) / `PCFU_CLK_PERIOD_NS)

`endif

// [pcfu_pkg.sv]
package pcfu_pkg;

    // read data word of the register bus
    typedef logic [15:0] pcfu_rdata_t;

    // unlock detector states
    typedef enum logic [1:0] {
        ul_idle = 2'b01,
        ul_armed = 2'b10
    } pcfu_unlock_state_t;

    // clock source switch states
    typedef enum logic [2:0] {
        sw_osc = 3'b001,
        sw_break = 3'b010,
        sw_pll = 3'b100
    } pcfu_switch_state_t;

endpackage

// [pcfu_link_if.sv]
interface pcfu_link_if;
    // bus cycle view for the unlock detector
    logic bus_cyc;
    logic bus_wr;
    logic feed_hit;
    logic [7:0] wdata;
    logic commit;
    // clock source request and gate state
    logic want_pll;
    logic osc_gate;
    logic pll_gate;

    modport unlock_dev (input bus_cyc, input bus_wr, input feed_hit, input wdata, output commit);
    modport unlock_user (output bus_cyc, output bus_wr, output feed_hit, output wdata, input commit);
    modport switch_dev (input want_pll, output osc_gate, output pll_gate);
    modport switch_user (output want_pll, input osc_gate, input pll_gate);
endinterface

// [pcfu_unlock_det.sv]
`include "pcfu_params.svh"

module pcfu_unlock_det (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic nrst_in,
    // bus view and commit pulse
    pcfu_link_if.unlock_dev link
);
    import pcfu_pkg::*;

    pcfu_unlock_state_t state_q;
    pcfu_unlock_state_t state_d;
    logic commit_q;
    logic commit_d;

    // key decode on writes to the unlock register
    wire feed_wr = link.bus_cyc & link.bus_wr & link.feed_hit;
    wire key_first = feed_wr & (link.wdata == `PCFU_KEY_FIRST);
    wire key_second = feed_wr & (link.wdata == `PCFU_KEY_SECOND);

    // idle clocks do not break the pair, only another bus cycle does
    // relies on software keeping interrupts off between the two writes
    always_comb begin
        state_d = state_q;
        commit_d = 1'b0;
        case (state_q)
            ul_idle: begin
                if (key_first) begin
                    state_d = ul_armed;
                end
            end
            ul_armed: begin
                // any next cycle returns to idle, only the second key commits
                if (link.bus_cyc) begin
                    state_d = ul_idle;
                    commit_d = key_second;
                end
            end
            default: begin
                state_d = ul_idle;
            end
        endcase
    end

    // state and commit pulse
    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            state_q <= ul_idle;
            commit_q <= 1'b0;
        end else begin
            state_q <= state_d;
            commit_q <= commit_d;
        end
    end

    assign link.commit = commit_q;

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!nrst_in);

    a_commit_needs_pair: assert property (commit_q |-> $past(key_second) && $past(state_q == ul_armed))
        else $error("commit without first then second key");
    a_wrong_cycle_idle: assert property (state_q == ul_armed && link.bus_cyc && !key_second |=> state_q == ul_idle && !commit_q)
        else $error("detector stayed armed or committed after a foreign cycle");
    c_good_pair: cover property (key_first ##[1:4] key_second ##1 commit_q);
endmodule

// [pcfu_clk_switch.sv]
`include "pcfu_params.svh"

module pcfu_clk_switch #(
    parameter int BREAK_CYC = `PCFU_BREAK_CYC
) (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic nrst_in,
    // request and gates
    pcfu_link_if.switch_dev link
);
    import pcfu_pkg::*;

    pcfu_switch_state_t state_q;
    pcfu_switch_state_t state_d;
    logic [2:0] cnt_q;
    logic [2:0] cnt_d;
    logic osc_gate_q;
    logic pll_gate_q;

    wire break_done = (cnt_q == 3'(BREAK_CYC - 1));

    // break before make, both gates low for the whole gap
    always_comb begin
        state_d = state_q;
        cnt_d = 3'h0;
        case (state_q)
            sw_osc: begin
                if (link.want_pll) begin
                    state_d = sw_break;
                end
            end
            sw_pll: begin
                if (!link.want_pll) begin
                    state_d = sw_break;
                end
            end
            sw_break: begin
                // target is taken at the end of the gap, so a request that flips mid-gap wins
                if (break_done) begin
                    state_d = link.want_pll ? sw_pll : sw_osc;
                end else begin
                    cnt_d = cnt_q + 3'h1;
                end
            end
            default: begin
                state_d = sw_break;
            end
        endcase
    end

    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            state_q <= sw_osc;
            cnt_q <= 3'h0;
            osc_gate_q <= 1'b1;
            pll_gate_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            osc_gate_q <= (state_d == sw_osc);
            pll_gate_q <= (state_d == sw_pll);
        end
    end

    assign link.osc_gate = osc_gate_q;
    assign link.pll_gate = pll_gate_q;

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!nrst_in);

    a_gates_exclusive: assert property (!(osc_gate_q && pll_gate_q))
        else $error("both clock gates open");
    a_break_gap: assert property ($fell(pll_gate_q) || $fell(osc_gate_q) |-> (!osc_gate_q && !pll_gate_q) [*4])
        else $error("gap between clock sources too short");
    c_to_pll: cover property ($rose(pll_gate_q));
endmodule

// [pcfu_feed_unit_test.sv]
`include "pcfu_params.svh"

module pcfu_feed_unit_test import pcfu_pkg::*; ;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int GAP = 4;
    localparam int LIMIT = 5000;

    // stimulus, all given a value at time zero
    logic sys_clk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic sel = 1'b0;
    logic wr = 1'b0;
    logic [31:0] addr = 32'h0000_0000;
    logic [7:0] wdata = 8'h00;
    logic lock = 1'b0;
    logic pd = 1'b0;
    // observed outputs
    pcfu_rdata_t rdata;
    logic en_o;
    logic [4:0] mult;
    logic [1:0] div;
    logic osc_g;
    logic pll_g;
    logic irq;
    int failures = 0;
    int tests_run = 0;
    int cycles = 0;

    pcfu_feed_unit #(.BREAK_CYC(GAP)) dut (
        .sys_clk_in(sys_clk_in),
        .nrst_in(nrst_in),
        .bus_sel_in(sel),
        .bus_wr_in(wr),
        .bus_addr_in(addr),
        .bus_wdata_in(wdata),
        .bus_rdata_out(rdata),
        .lock_in(lock),
        .power_down_in(pd),
        .pll_enable_out(en_o),
        .pll_mult_out(mult),
        .pll_div_out(div),
        .osc_clk_gate_out(osc_g),
        .pll_clk_gate_out(pll_g),
        .lock_irq_out(irq)
    );

    // 200 MHz system clock
    initial begin
        forever #2.5 sys_clk_in = ~sys_clk_in;
    end

    task automatic wrap_up();
        $display("checks=%0d failures=%0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // a hang ends the run through the same report
    always @(posedge sys_clk_in) begin
        cycles++;
        if (cycles == LIMIT) begin
            failures++;
            wrap_up();
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one bus cycle; sel stays high so calls in a row are back to back
    task automatic cyc(input logic w, input logic [31:0] a, input logic [7:0] d);
        @(negedge sys_clk_in);
        sel = 1'b1;
        wr = w;
        addr = a;
        wdata = d;
    endtask

    task automatic idle();
        @(negedge sys_clk_in);
        sel = 1'b0;
    endtask

    task automatic wr_reg(input logic [31:0] a, input logic [7:0] d);
        cyc(1'b1, a, d);
        idle();
    endtask

    // read data lands on the edge that takes the read
    task automatic rd_chk(input logic [31:0] a, input logic [15:0] exp);
        cyc(1'b0, a, 8'h00);
        idle();
        chk(rdata, exp);
    endtask

    task automatic feed(input logic [7:0] k1, input logic [7:0] k2);
        cyc(1'b1, `PCFU_ADDR_FEED, k1);
        cyc(1'b1, `PCFU_ADDR_FEED, k2);
        idle();
    endtask

    // follow a source change: never both gates open, gap of exactly GAP cycles
    task automatic sw_wait(input logic to_pll);
        int gap;
        int n;
        gap = 0;
        for (n = 0; n < 30 && (to_pll ? pll_g : osc_g) !== 1'b1; n++) begin
            @(negedge sys_clk_in);
            if (osc_g === 1'b1 && pll_g === 1'b1) begin
                chk(16'h0011, 16'h0000);
            end
            if (osc_g === 1'b0 && pll_g === 1'b0) begin
                gap++;
            end
        end
        chk(16'({osc_g, pll_g}), to_pll ? 16'h0001 : 16'h0002);
        chk(16'(gap), 16'(GAP));
    endtask

    // main sequence, each step launched off the falling edge
    initial begin
        repeat (8) @(posedge sys_clk_in);
        @(negedge sys_clk_in);
        nrst_in = 1'b1;
        chk(16'({osc_g, pll_g, en_o, irq}), 16'h0008);
        rd_chk(`PCFU_ADDR_STAT, 16'h0000);
        // reserved bits dropped, pending readable
        wr_reg(`PCFU_ADDR_CTRL, 8'hFF);
        wr_reg(`PCFU_ADDR_CFG, 8'hA5);
        rd_chk(`PCFU_ADDR_CTRL, 16'h0003);
        rd_chk(`PCFU_ADDR_CFG, 16'h0025);
        rd_chk(`PCFU_ADDR_STAT, 16'h0000);
        // broken unlock attempts leave active values alone
        feed(8'hAB, 8'h55);
        rd_chk(`PCFU_ADDR_STAT, 16'h0000);
        feed(8'h55, 8'hAA);
        rd_chk(`PCFU_ADDR_STAT, 16'h0000);
        cyc(1'b1, `PCFU_ADDR_FEED, 8'hAA);
        cyc(1'b0, `PCFU_ADDR_STAT, 8'h00);
        cyc(1'b1, `PCFU_ADDR_FEED, 8'h55);
        idle();
        rd_chk(`PCFU_ADDR_STAT, 16'h0000);
        cyc(1'b1, `PCFU_ADDR_FEED, 8'hAA);
        feed(8'hAA, 8'h55);
        rd_chk(`PCFU_ADDR_STAT, 16'h0000);
        // enable only: loop runs, oscillator still drives
        wr_reg(`PCFU_ADDR_CTRL, 8'h01);
        wr_reg(`PCFU_ADDR_CFG, 8'h25);
        feed(8'hAA, 8'h55);
        rd_chk(`PCFU_ADDR_STAT, 16'h0125);
        chk(16'({en_o, div, mult}), 16'h00A5);
        chk(16'({osc_g, pll_g}), 16'h0002);
        wr_reg(`PCFU_ADDR_CFG, 8'h1F);
        rd_chk(`PCFU_ADDR_STAT, 16'h0125);
        // connect without enable behaves as all off
        wr_reg(`PCFU_ADDR_CTRL, 8'h02);
        feed(8'hAA, 8'h55);
        rd_chk(`PCFU_ADDR_STAT, 16'h021F);
        chk(16'({en_o, osc_g, pll_g}), 16'h0002);
        // connect while unlocked: no lock check, glitch-free switch
        wr_reg(`PCFU_ADDR_CTRL, 8'h03);
        feed(8'hAA, 8'h55);
        sw_wait(1'b1);
        rd_chk(`PCFU_ADDR_STAT, 16'h031F);
        // lock reported in status and to the interrupt controller
        @(negedge sys_clk_in);
        lock = 1'b1;
        repeat (3) @(negedge sys_clk_in);
        chk(16'(irq), 16'h0001);
        rd_chk(`PCFU_ADDR_STAT, 16'h071F);
        lock = 1'b0;
        repeat (4) @(negedge sys_clk_in);
        chk(16'({irq, osc_g, pll_g}), 16'h0001);
        rd_chk(`PCFU_ADDR_STAT, 16'h031F);
        // status is read only, unmapped and unlock reads give zero
        wr_reg(`PCFU_ADDR_STAT, 8'hFF);
        rd_chk(`PCFU_ADDR_STAT, 16'h031F);
        rd_chk(32'hE01F_C090, 16'h0000);
        rd_chk(`PCFU_ADDR_FEED, 16'h0000);
        // power down forces off and back to the oscillator
        @(negedge sys_clk_in);
        pd = 1'b1;
        sw_wait(1'b0);
        rd_chk(`PCFU_ADDR_STAT, 16'h001F);
        chk(16'(en_o), 16'h0000);
        pd = 1'b0;
        lock = 1'b0;
        repeat (4) @(negedge sys_clk_in);
        rd_chk(`PCFU_ADDR_STAT, 16'h001F);
        chk(16'({en_o, osc_g, pll_g}), 16'h0002);
        // wakeup set-up the safe way: enable, wait for lock, then connect
        wr_reg(`PCFU_ADDR_CTRL, 8'h01);
        // idle clocks between the two keys do not break the pair
        cyc(1'b1, `PCFU_ADDR_FEED, 8'hAA);
        idle();
        cyc(1'b1, `PCFU_ADDR_FEED, 8'h55);
        idle();
        rd_chk(`PCFU_ADDR_STAT, 16'h011F);
        chk(16'({en_o, osc_g, pll_g}), 16'h0006);
        lock = 1'b1;
        repeat (3) @(negedge sys_clk_in);
        chk(16'(irq), 16'h0001);
        wr_reg(`PCFU_ADDR_CTRL, 8'h03);
        feed(8'hAA, 8'h55);
        sw_wait(1'b1);
        rd_chk(`PCFU_ADDR_STAT, 16'h071F);
        wrap_up();
    end
endmodule
